// ==== link_enhance_regs.vh ====
`ifndef LINK_ENHANCE_REGS_VH
`define LINK_ENHANCE_REGS_VH

// ----------------------------------------------------------------------------
// configuration offsets
// ----------------------------------------------------------------------------
`define CFG_ADDR_W           8
`define ENH_CTRL_OFFSET      8'hf0
`define SUBSYS_ALIAS_OFFSET  8'hf8
`define CFG_RD_RESET         32'h00000000

// ----------------------------------------------------------------------------
// enhancement control field layout (lower part)
// ----------------------------------------------------------------------------
`define ENH_W                11
`define ENH_MPEG_BIT         10
`define ENH_RSVD9_BIT        9
`define ENH_DV_BIT           8
`define ENH_PRIO_BIT         7
`define ENH_RSVD_HI          6
`define ENH_RSVD_LO          3
`define ENH_TUNE_BIT         2
`define ENH_ACCEL_BIT        1
`define ENH_RSVD0_BIT        0
`define ENH_WRITE_MASK       11'h586
`define ENH_RESET            11'h000

// ----------------------------------------------------------------------------
// subsystem alias field layout
// ----------------------------------------------------------------------------
`define SUBSYS_W             32
`define SUBSYS_DEV_HI        31
`define SUBSYS_DEV_LO        16
`define SUBSYS_VEN_HI        15
`define SUBSYS_VEN_LO        0
`define SUBSYS_WRITE_MASK    32'hffffffff
`define SUBSYS_RESET         32'h00000000

// ----------------------------------------------------------------------------
// stream format codes
// ----------------------------------------------------------------------------
`define FMT_W                6
`define FMT_MPEG             6'h20
`define FMT_DV               6'h00

`endif

// ==== byte_lane_reg.v ====
`timescale 1ns/1ps
`default_nettype none

module byte_lane_reg #(
    parameter integer        WIDTH      = 32,
    parameter [WIDTH-1:0]    RESET_VAL  = {WIDTH{1'b0}},
    parameter [WIDTH-1:0]    WRITE_MASK = {WIDTH{1'b1}}
) (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   rstn,
    // write port
    input  wire                   wrEn,
    input  wire [(WIDTH+7)/8-1:0] byteEn,
    input  wire [WIDTH-1:0]       wrData,
    // stored value
    output wire [WIDTH-1:0]       value
);

    reg [WIDTH-1:0] value_reg;

    assign value = value_reg;

    // ------------------------------------------------------------------------
    // one flop per bit, written only when its lane is enabled and it is writable
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge ref_clk) begin
                if (!rstn) begin
                    value_reg[i] <= RESET_VAL[i];
                end else if (wrEn && byteEn[i/8] && WRITE_MASK[i]) begin
                    value_reg[i] <= wrData[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== stamp_select.v ====
`timescale 1ns/1ps
`default_nettype none
`include "link_enhance_regs.vh"

module stamp_select (
    // clock and reset
    input  wire               ref_clk,
    input  wire               rstn,
    // enables
    input  wire               mpegEn,
    input  wire               dvEn,
    // stream under transmit
    input  wire [`FMT_W-1:0]  streamFormatCode,
    // result
    output reg                stampBoostActive
);

    // ------------------------------------------------------------------------
    // registered match of the stream format against the enabled formats
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            stampBoostActive <= 1'b0;
        end else begin
            stampBoostActive <= (mpegEn && (streamFormatCode == `FMT_MPEG)) || // RULE1
                                (dvEn && (streamFormatCode == `FMT_DV));       // RULE3
        end
    end

endmodule

`default_nettype wire

// ==== link_enhance_subsys_alias_regs.v ====
// How it works
// RULE1: bit 10 enables MPEG stamp boost, format 20h
// RULE2: bit 9 reserved, reads zero
// RULE3: bit 8 enables DV stamp boost, format 00h
// RULE4: bit 7 enables priority arbitration responses
// RULE5: bits 6 to 3 reserved, read zero
// RULE6: software keeps writable bit 2 at zero
// RULE7: bit 1 tells PHY acceleration is supported
// RULE8: bit 0 reserved, reads zero
// RULE9: writable enable bits reset to zero
// RULE10: alias at F8h, writes update subsystem identifiers
// RULE11: alias reads back last written value
// RULE12: device ident high half, vendor low half
// RULE13: alias resets to all zeros
// RULE14: byte enables gate writes, reserved bits untouched
`timescale 1ns/1ps
`default_nettype none
`include "link_enhance_regs.vh"

module link_enhance_subsys_alias_regs (
    // clock and reset
    input  wire                    ref_clk,
    input  wire                    rstn,

    // configuration write request
    input  wire                    cfgWrEn,
    input  wire [`CFG_ADDR_W-1:0]  cfgAddr,
    input  wire [3:0]              cfgByteEn,
    input  wire [31:0]             cfgWrData,

    // configuration read request and answer
    input  wire                    cfgRdEn,
    output reg  [31:0]             cfgRdData,
    output reg                     cfgRdValid,
    output reg                     cfgWrAck,

    // transmit stream side
    input  wire [`FMT_W-1:0]       streamFormatCode,
    output wire                    stampBoostActive,

    // enables to the link core and PHY interface
    output wire                    mpegStampBoostEn,
    output wire                    dvStampBoostEn,
    output wire                    priorityArbEn,
    output wire                    accelEnhanceEn,
    output wire                    coreTuneBit,

    // subsystem identifier registers
    output wire [15:0]             subsysDeviceIdent,
    output wire [15:0]             subsysVendorIdent
);

    // ------------------------------------------------------------------------
    // address decode helper, shared by write and read paths
    // ------------------------------------------------------------------------
    function hit;
        input [`CFG_ADDR_W-1:0] addr;
        input [`CFG_ADDR_W-1:0] offset;
        begin
            hit = (addr[`CFG_ADDR_W-1:2] == offset[`CFG_ADDR_W-1:2]);
        end
    endfunction

    wire             enhWr;
    wire             subsysWr;
    wire [`ENH_W-1:0]    enhValue;
    wire [`SUBSYS_W-1:0] subsysValue;
    reg  [31:0]      rdData_next;

    // ------------------------------------------------------------------------
    // write strobes per register
    // ------------------------------------------------------------------------
    assign enhWr    = cfgWrEn && hit(cfgAddr, `ENH_CTRL_OFFSET);
    assign subsysWr = cfgWrEn && hit(cfgAddr, `SUBSYS_ALIAS_OFFSET); // RULE10

    // ------------------------------------------------------------------------
    // enhancement control storage; only writable bits get flops that change
    // ------------------------------------------------------------------------
    byte_lane_reg #(
        .WIDTH      (`ENH_W),
        .RESET_VAL  (`ENH_RESET),      // RULE9
        .WRITE_MASK (`ENH_WRITE_MASK)  // RULE14
    ) u_enh (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wrEn    (enhWr),
        .byteEn  (cfgByteEn[1:0]),     // RULE14
        .wrData  (cfgWrData[`ENH_W-1:0]),
        .value   (enhValue)
    );

    // ------------------------------------------------------------------------
    // subsystem alias storage, doubling as the identifier registers
    // ------------------------------------------------------------------------
    byte_lane_reg #(
        .WIDTH      (`SUBSYS_W),
        .RESET_VAL  (`SUBSYS_RESET),      // RULE13
        .WRITE_MASK (`SUBSYS_WRITE_MASK)
    ) u_subsys (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wrEn    (subsysWr),              // RULE10
        .byteEn  (cfgByteEn),             // RULE14
        .wrData  (cfgWrData),
        .value   (subsysValue)
    );

    // ------------------------------------------------------------------------
    // enable outputs straight from the storage flops
    // ------------------------------------------------------------------------
    assign mpegStampBoostEn  = enhValue[`ENH_MPEG_BIT];                // RULE1
    assign dvStampBoostEn    = enhValue[`ENH_DV_BIT];                  // RULE3
    assign priorityArbEn     = enhValue[`ENH_PRIO_BIT];                // RULE4
    assign accelEnhanceEn    = enhValue[`ENH_ACCEL_BIT];               // RULE7
    assign coreTuneBit       = enhValue[`ENH_TUNE_BIT];                // RULE6
    assign subsysDeviceIdent = subsysValue[`SUBSYS_DEV_HI:`SUBSYS_DEV_LO]; // RULE12
    assign subsysVendorIdent = subsysValue[`SUBSYS_VEN_HI:`SUBSYS_VEN_LO]; // RULE12

    // ------------------------------------------------------------------------
    // stream format match for the stamp boost
    // ------------------------------------------------------------------------
    stamp_select u_stamp (
        .ref_clk          (ref_clk),
        .rstn             (rstn),
        .mpegEn           (mpegStampBoostEn),
        .dvEn             (dvStampBoostEn),
        .streamFormatCode (streamFormatCode),
        .stampBoostActive (stampBoostActive)
    );

    // ------------------------------------------------------------------------
    // read mux; reserved and unmapped bits read as zero
    // ------------------------------------------------------------------------
    always @* begin
        rdData_next = 32'h00000000;
        if (hit(cfgAddr, `ENH_CTRL_OFFSET)) begin
            rdData_next[`ENH_MPEG_BIT]  = enhValue[`ENH_MPEG_BIT];
            rdData_next[`ENH_RSVD9_BIT] = 1'b0;                        // RULE2
            rdData_next[`ENH_DV_BIT]    = enhValue[`ENH_DV_BIT];
            rdData_next[`ENH_PRIO_BIT]  = enhValue[`ENH_PRIO_BIT];
            rdData_next[`ENH_RSVD_HI:`ENH_RSVD_LO] = 4'h0;            // RULE5
            rdData_next[`ENH_TUNE_BIT]  = enhValue[`ENH_TUNE_BIT];
            rdData_next[`ENH_ACCEL_BIT] = enhValue[`ENH_ACCEL_BIT];
            rdData_next[`ENH_RSVD0_BIT] = 1'b0;                        // RULE8
        end else if (hit(cfgAddr, `SUBSYS_ALIAS_OFFSET)) begin
            rdData_next = subsysValue;                                 // RULE11
        end
    end

    // ------------------------------------------------------------------------
    // registered read answer and write acknowledge, one cycle after request
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cfgRdData  <= `CFG_RD_RESET;
            cfgRdValid <= 1'b0;
            cfgWrAck   <= 1'b0;
        end else begin
            cfgRdValid <= cfgRdEn && !cfgWrEn;
            cfgWrAck   <= cfgWrEn;
            if (cfgRdEn && !cfgWrEn) begin
                cfgRdData <= rdData_next;
            end
        end
    end

endmodule

`default_nettype wire

// ==== link_enhance_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_enhance_monitor (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // register access
    input wire logic        cfgWrEn,
    input wire logic [7:0]  cfgAddr,
    input wire logic [3:0]  cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic        cfgRdEn,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgRdValid,
    input wire logic        cfgWrAck,
    // stream and enables
    input wire logic [5:0]  streamFormatCode,
    input wire logic        stampBoostActive,
    input wire logic        mpegStampBoostEn,
    input wire logic        dvStampBoostEn,
    input wire logic        priorityArbEn,
    input wire logic        accelEnhanceEn,
    input wire logic [15:0] subsysDeviceIdent,
    input wire logic [15:0] subsysVendorIdent
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    wire enhHit = cfgAddr[7:2] == 6'h3c;
    wire subHit = cfgAddr[7:2] == 6'h3e;
    wire rdGo   = cfgRdEn && !cfgWrEn;
    wire boostCause = (mpegStampBoostEn && streamFormatCode == 6'h20) ||
                      (dvStampBoostEn && streamFormatCode == 6'h00);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    chk_hi_lane_enables: assert property (cfgWrEn && enhHit && cfgByteEn[1] |=>
        mpegStampBoostEn == $past(cfgWrData[10]) && dvStampBoostEn == $past(cfgWrData[8]))
        else $error("high lane enables not written");
    chk_lo_lane_enables: assert property (cfgWrEn && enhHit && cfgByteEn[0] |=>
        priorityArbEn == $past(cfgWrData[7]) && accelEnhanceEn == $past(cfgWrData[1]))
        else $error("low lane enables not written");
    chk_reset_clears: assert property (disable iff (1'b0) !rstn |=>
        !mpegStampBoostEn && !dvStampBoostEn && !priorityArbEn && !accelEnhanceEn &&
        subsysDeviceIdent == 16'h0000 && subsysVendorIdent == 16'h0000)
        else $error("reset did not clear registers");
    chk_alias_write: assert property (cfgWrEn && subHit && cfgByteEn == 4'hf |=>
        {subsysDeviceIdent, subsysVendorIdent} == $past(cfgWrData))
        else $error("alias write not reflected");
    chk_alias_read: assert property (rdGo && subHit |=> cfgRdValid &&
        cfgRdData == {$past(subsysDeviceIdent), $past(subsysVendorIdent)})
        else $error("alias read mismatch");
    chk_byte_hold: assert property (cfgWrEn && subHit && !cfgByteEn[3] |=>
        $stable(subsysDeviceIdent[15:8])) else $error("disabled byte changed");
    chk_reserved_zero: assert property (rdGo && enhHit |=> cfgRdValid &&
        cfgRdData[31:11] == 21'h0 && !cfgRdData[9] && cfgRdData[6:3] == 4'h0 && !cfgRdData[0])
        else $error("reserved bits not zero");
    chk_boost_latency: assert property (stampBoostActive == $past(boostCause))
        else $error("stamp boost mismatch");
    chk_write_ack: assert property (cfgWrEn |=> cfgWrAck)
        else $error("write not acknowledged");
    cov_boost: cover property (stampBoostActive);
    cov_alias_rd: cover property (rdGo && subHit);
    cov_part_wr: cover property (cfgWrEn && cfgByteEn != 4'hf);
endmodule
bind link_enhance_subsys_alias_regs link_enhance_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
    .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgWrAck(cfgWrAck),
    .streamFormatCode(streamFormatCode), .stampBoostActive(stampBoostActive),
    .mpegStampBoostEn(mpegStampBoostEn), .dvStampBoostEn(dvStampBoostEn),
    .priorityArbEn(priorityArbEn), .accelEnhanceEn(accelEnhanceEn),
    .subsysDeviceIdent(subsysDeviceIdent), .subsysVendorIdent(subsysVendorIdent));
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cfgWrEn = 1'b0;
    logic        cfgRdEn = 1'b0;
    logic [7:0]  cfgAddr = 8'h00;
    logic [3:0]  cfgByteEn = 4'h0;
    logic [31:0] cfgWrData = 32'h0;
    logic [5:0]  streamFormatCode = 6'h3f;
    wire  [31:0] cfgRdData;
    wire         cfgRdValid, cfgWrAck, stampBoostActive, coreTuneBit;
    wire         mpegStampBoostEn, dvStampBoostEn, priorityArbEn, accelEnhanceEn;
    wire  [15:0] subsysDeviceIdent, subsysVendorIdent;
    int          failures = 0;
    int          checksDone = 0;
    // free-running clock
    always #4 ref_clk = ~ref_clk;
    link_enhance_subsys_alias_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .cfgWrEn(cfgWrEn),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgWrAck(cfgWrAck),
        .streamFormatCode(streamFormatCode), .stampBoostActive(stampBoostActive),
        .mpegStampBoostEn(mpegStampBoostEn), .dvStampBoostEn(dvStampBoostEn),
        .priorityArbEn(priorityArbEn), .accelEnhanceEn(accelEnhanceEn),
        .coreTuneBit(coreTuneBit), .subsysDeviceIdent(subsysDeviceIdent),
        .subsysVendorIdent(subsysVendorIdent));
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge ref_clk);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWrData = d;
        @(negedge ref_clk);
        cfgWrEn = 1'b0;
        `CHK(cfgWrAck, 1'b1)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge ref_clk);
        cfgRdEn = 1'b1;
        cfgAddr = a;
        @(negedge ref_clk);
        cfgRdEn = 1'b0;
        `CHK(cfgRdValid, 1'b1)
        `CHK(cfgRdData, e)
    endtask
    task automatic fmt(input logic [5:0] f, input logic e);
        @(negedge ref_clk);
        streamFormatCode = f;
        @(negedge ref_clk);
        `CHK(stampBoostActive, e)
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        rd(8'hf0, 32'h0);
        rd(8'hf8, 32'h0);
        // software keeps bit 2 clear, every other bit is driven high
        wr(8'hf0, 4'h1, 32'hfffffffb);
        rd(8'hf0, 32'h82);
        wr(8'hf0, 4'hf, 32'hfffffffb);
        rd(8'hf0, 32'h582);
        `CHK({mpegStampBoostEn, dvStampBoostEn, priorityArbEn, accelEnhanceEn}, 4'hf)
        wr(8'hf0, 4'hf, 32'h502);
        `CHK({priorityArbEn, coreTuneBit}, 2'b00)
        fmt(6'h20, 1'b1);
        fmt(6'h00, 1'b1);
        fmt(6'h21, 1'b0);
        wr(8'hf0, 4'h2, 32'h100);
        fmt(6'h20, 1'b0);
        fmt(6'h00, 1'b1);
        wr(8'hf8, 4'hf, 32'h1234abcd);
        `CHK({subsysDeviceIdent, subsysVendorIdent}, 32'h1234abcd)
        wr(8'hf8, 4'h5, 32'hffffffff);
        rd(8'hf8, 32'h12ffabff);
        wr(8'hc0, 4'hf, 32'hffffffff);
        rd(8'hc0, 32'h0);
        rd(8'hf8, 32'h12ffabff);
        // read and write in one cycle: the write lands, the read is dropped
        @(negedge ref_clk);
        cfgWrEn = 1'b1;
        cfgRdEn = 1'b1;
        cfgAddr = 8'hf8;
        cfgByteEn = 4'hf;
        cfgWrData = 32'h0000beef;
        @(negedge ref_clk);
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        `CHK({cfgWrAck, cfgRdValid}, 2'b10)
        rd(8'hf8, 32'h0000beef);
        // mid-run reset held two cycles clears every written bit
        @(negedge ref_clk);
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK({mpegStampBoostEn, dvStampBoostEn, accelEnhanceEn, stampBoostActive}, 4'h0)
        rd(8'hf0, 32'h0);
        rd(8'hf8, 32'h0);
        tally_and_finish();
    end
    // watchdog: the tests need well under 200 cycles, so 2000 means a hang
    initial begin
        repeat (2000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
